// ---- tcgc_pkg.sv ----
// Package for the compare, gated and capture/compare timer with an APB register port.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package tcgc_pkg;
    localparam logic [11:0] ADDR_CTL0 = 12'h000;
    localparam logic [11:0] ADDR_CTL1 = 12'h004;
    localparam logic [11:0] ADDR_CNTH = 12'h008;
    localparam logic [11:0] ADDR_CNTL = 12'h00C;
    localparam logic [11:0] ADDR_RLDH = 12'h010;
    localparam logic [11:0] ADDR_RLDL = 12'h014;
    localparam logic [11:0] ADDR_CAPH = 12'h018;
    localparam logic [11:0] ADDR_CAPL = 12'h01C;
    localparam logic [11:0] ADDR_OUTC = 12'h020;
    // Control zero fields
    localparam int CTL0_CAUSE_BIT = 0;
    localparam int CTL0_SEL_LSB = 5;
    localparam int CTL0_MSB_BIT = 7;
    // Control one fields
    localparam int CTL1_MODE_LSB = 0;
    localparam int CTL1_PRES_LSB = 3;
    localparam int CTL1_POL_BIT = 6;
    localparam int CTL1_EN_BIT = 7;
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] RLD_RESET = 16'hFFFF;
    localparam logic [15:0] CNT_RESTART = 16'h0001;
    // Mode codes, msb from control zero, low bits from control one
    localparam logic [3:0] MODE_COMPARE = 4'h2;
    localparam logic [3:0] MODE_GATED = 4'h6;
    localparam logic [3:0] MODE_CAPCMP = 4'h7;
    localparam logic [3:0] MODE_DUALPWM = 4'h8;
    // Interrupt source select codes
    localparam logic [1:0] SEL_INPUT = 2'h2;
    localparam logic [1:0] SEL_RELOAD = 2'h3;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] capture;
        logic [7:0] holdLow;
        logic [6:0] prescale;
        logic outLevel;
        logic outEnable;
        logic inPrev;
        logic armed;
        logic irq;
        logic [31:0] prdata;
    } tcgc_state_s;
endpackage

// ---- tcgc_timer.sv ----
// Timer core with APB slave, capture, gated and compare counting.
// Assumes input pin and APB signals synchronous to clock.
`timescale 1ns/1ps
module tcgc_timer
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timerIn,
    output logic timerOut,
    output logic timerOutComp,
    output logic timerOutCompEnN,
    output logic timerIrq
);
    tcgc_pkg::tcgc_state_s state_r;
    tcgc_pkg::tcgc_state_s state_nxt;

    logic enabled;
    logic pol;
    logic [3:0] mode;
    logic [1:0] sel;
    logic [2:0] pres;
    logic tick;
    logic active;
    logic edgeSel;
    logic inputIrqOk;
    logic reloadIrqOk;
    logic wr;
    logic rd;
    logic mapped;

    function automatic logic [6:0] presLimit(input logic [2:0] p);
        // Divide by 2**p, terminal count at 2**p - 1
        presLimit = 7'((8'h01 << p) - 8'h01);
    endfunction

    assign enabled = state_r.ctl1[tcgc_pkg::CTL1_EN_BIT];
    assign pol = state_r.ctl1[tcgc_pkg::CTL1_POL_BIT];
    assign mode = {state_r.ctl0[tcgc_pkg::CTL0_MSB_BIT], state_r.ctl1[tcgc_pkg::CTL1_MODE_LSB +: 3]};
    assign sel = state_r.ctl0[tcgc_pkg::CTL0_SEL_LSB +: 2];
    assign pres = state_r.ctl1[tcgc_pkg::CTL1_PRES_LSB +: 3];
    assign tick = enabled && (state_r.prescale == presLimit(pres));
    assign active = (timerIn == pol);
    assign edgeSel = (timerIn == pol) && (state_r.inPrev != pol);
    assign inputIrqOk = (sel != tcgc_pkg::SEL_RELOAD);
    assign reloadIrqOk = (sel != tcgc_pkg::SEL_INPUT);
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = (paddr <= tcgc_pkg::ADDR_OUTC) && (paddr[1:0] == 2'h0);

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.irq = 1'b0;
        state_nxt.inPrev = timerIn;
        if (!enabled)
        begin
            state_nxt.prescale = 7'h00;
            state_nxt.armed = 1'b0;
        end
        else if (tick)
        begin
            state_nxt.prescale = 7'h00;
        end
        else
        begin
            state_nxt.prescale = 7'(state_r.prescale + 7'h01);
        end

        if (enabled)
        begin
            unique case (mode)
                tcgc_pkg::MODE_COMPARE:
                begin
                    if (tick)
                    begin
                        state_nxt.count = 16'(state_r.count + 16'h0001);
                        if (state_r.count == state_r.reload)
                        begin
                            state_nxt.irq = reloadIrqOk;
                            state_nxt.ctl0[tcgc_pkg::CTL0_CAUSE_BIT] = 1'b0;
                            state_nxt.outLevel = !state_r.outLevel;
                        end
                    end
                end
                tcgc_pkg::MODE_GATED:
                begin
                    if (state_r.inPrev == pol && !active)
                    begin
                        state_nxt.irq = inputIrqOk;
                        state_nxt.ctl0[tcgc_pkg::CTL0_CAUSE_BIT] = 1'b0;
                    end
                    if (tick && active)
                    begin
                        if (state_r.count == state_r.reload)
                        begin
                            state_nxt.count = tcgc_pkg::CNT_RESTART;
                            state_nxt.irq = reloadIrqOk | state_nxt.irq;
                            state_nxt.outLevel = !state_r.outLevel;
                        end
                        else
                        begin
                            state_nxt.count = 16'(state_r.count + 16'h0001);
                        end
                    end
                end
                tcgc_pkg::MODE_CAPCMP:
                begin
                    // first edge only arms, no interrupt
                    if (!state_r.armed)
                    begin
                        state_nxt.armed = edgeSel;
                    end
                    else if (edgeSel)
                    begin
                        state_nxt.capture = state_r.count;
                        state_nxt.count = tcgc_pkg::CNT_RESTART;
                        state_nxt.ctl0[tcgc_pkg::CTL0_CAUSE_BIT] = 1'b1;
                        state_nxt.irq = inputIrqOk;
                    end
                    else if (tick)
                    begin
                        if (state_r.count == state_r.reload)
                        begin
                            state_nxt.count = tcgc_pkg::CNT_RESTART;
                            state_nxt.ctl0[tcgc_pkg::CTL0_CAUSE_BIT] = 1'b0;
                            state_nxt.irq = reloadIrqOk;
                            state_nxt.outLevel = !state_r.outLevel;
                        end
                        else
                        begin
                            state_nxt.count = 16'(state_r.count + 16'h0001);
                        end
                    end
                end
                default:
                begin
                    state_nxt.count = state_r.count;
                end
            endcase
        end

        // Register writes take effect at the access edge
        if (wr && mapped)
        begin
            unique case (paddr)
                tcgc_pkg::ADDR_CTL0:
                begin
                    state_nxt.ctl0 = {pwdata[7:1], state_nxt.ctl0[tcgc_pkg::CTL0_CAUSE_BIT]};
                end
                tcgc_pkg::ADDR_CTL1:
                begin
                    if (!enabled)
                    begin
                        state_nxt.outLevel = pwdata[tcgc_pkg::CTL1_POL_BIT];
                    end
                    state_nxt.ctl1 = pwdata[7:0];
                end
                tcgc_pkg::ADDR_CNTH: state_nxt.count[15:8] = pwdata[7:0];
                tcgc_pkg::ADDR_CNTL: state_nxt.count[7:0] = pwdata[7:0];
                tcgc_pkg::ADDR_RLDH: state_nxt.reload[15:8] = pwdata[7:0];
                tcgc_pkg::ADDR_RLDL: state_nxt.reload[7:0] = pwdata[7:0];
                tcgc_pkg::ADDR_CAPH: state_nxt.capture[15:8] = pwdata[7:0];
                tcgc_pkg::ADDR_CAPL: state_nxt.capture[7:0] = pwdata[7:0];
                tcgc_pkg::ADDR_OUTC: state_nxt.outEnable = pwdata[0];
                default: state_nxt.outEnable = state_nxt.outEnable;
            endcase
        end

        // reads leave counting untouched
        // Reads only touch the hold register and read data
        state_nxt.prdata = 32'h0000_0000;
        if (rd && mapped)
        begin
            unique case (paddr)
                tcgc_pkg::ADDR_CTL0: state_nxt.prdata = {24'h000000, state_r.ctl0};
                tcgc_pkg::ADDR_CTL1: state_nxt.prdata = {24'h000000, state_r.ctl1};
                tcgc_pkg::ADDR_CNTH:
                begin
                    state_nxt.prdata = {24'h000000, state_r.count[15:8]};
                    // latch low byte on high read
                    if (enabled)
                    begin
                        state_nxt.holdLow = state_r.count[7:0];
                    end
                end
                tcgc_pkg::ADDR_CNTL:
                begin
                    // held byte when enabled, live when not
                    state_nxt.prdata = {24'h000000, enabled ? state_r.holdLow : state_r.count[7:0]};
                end
                tcgc_pkg::ADDR_RLDH: state_nxt.prdata = {24'h000000, state_r.reload[15:8]};
                tcgc_pkg::ADDR_RLDL: state_nxt.prdata = {24'h000000, state_r.reload[7:0]};
                tcgc_pkg::ADDR_CAPH: state_nxt.prdata = {24'h000000, state_r.capture[15:8]};
                tcgc_pkg::ADDR_CAPL: state_nxt.prdata = {24'h000000, state_r.capture[7:0]};
                tcgc_pkg::ADDR_OUTC: state_nxt.prdata = {31'h00000000, state_r.outEnable};
                default: state_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_r.ctl0 <= tcgc_pkg::CTL0_RESET;
            state_r.ctl1 <= tcgc_pkg::CTL1_RESET;
            state_r.count <= tcgc_pkg::CNT_RESET;
            state_r.reload <= tcgc_pkg::RLD_RESET;
            state_r.capture <= tcgc_pkg::CNT_RESET;
            state_r.holdLow <= 8'h00;
            state_r.prescale <= 7'h00;
            state_r.outLevel <= 1'b0;
            state_r.outEnable <= 1'b0;
            state_r.inPrev <= 1'b0;
            state_r.armed <= 1'b0;
            state_r.irq <= 1'b0;
            state_r.prdata <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Zero-wait slave; read data taken from the next-state value, so returned by combinational path
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = state_nxt.prdata;
    assign timerOut = state_r.outLevel;
    assign timerIrq = state_r.irq;
    // pin is an output only in dual PWM mode with the output enable set; elsewhere an input
    assign timerOutComp = !state_r.outLevel;
    assign timerOutCompEnN = !(state_r.outEnable && mode == tcgc_pkg::MODE_DUALPWM);
endmodule // tcgc_timer

// ---- tcgc_chk.sv ----
// Port checker for the timer: APB answers, pin pairing, quiet states.
// Bound to tcgc_timer; sees only its ports.
`timescale 1ns/1ps
module tcgc_chk
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerIn,
    input wire logic timerOut,
    input wire logic timerOutComp,
    input wire logic timerOutCompEnN,
    input wire logic timerIrq
);
    logic enShadow_r;
    logic acc;
    logic ctl1Wr;
    assign acc = psel && penable;
    assign ctl1Wr = acc && pwrite && paddr == tcgc_pkg::ADDR_CTL1;
    // Mirror of the enable bit, seen from bus writes
    always_ff @(posedge clock)
    begin
        if (reset)
            enShadow_r <= 1'b0;
        else if (ctl1Wr)
            enShadow_r <= pwdata[tcgc_pkg::CTL1_EN_BIT];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_comp_pin: assert property (timerOutComp == !timerOut)
        else $error("complement pin not inverse of output");
    a_pin_dir: assert property ($changed(timerOutCompEnN) |-> $past(acc && pwrite))
        else $error("pin direction moved without a write");
    a_irq_enabled: assert property (timerIrq |-> enShadow_r || $past(enShadow_r) || $past(enShadow_r, 2))
        else $error("interrupt while disabled");
    a_out_idle: assert property ($changed(timerOut) && !enShadow_r && !$past(enShadow_r) |-> $past(ctl1Wr))
        else $error("output moved while disabled");
    a_read_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("read data outside read access");
    a_read_byte: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_map_err: assert property (acc && (paddr > tcgc_pkg::ADDR_OUTC || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    a_map_ok: assert property (acc && paddr <= tcgc_pkg::ADDR_OUTC && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_reset_quiet: assert property ($past(reset) |-> !timerIrq && !timerOut && timerOutCompEnN && pready)
        else $error("outputs not quiet after reset");
    c_irq: cover property (timerIrq);
    c_out_rise: cover property ($rose(timerOut));
    c_pin_out: cover property (!timerOutCompEnN);
endmodule // tcgc_chk

bind tcgc_timer tcgc_chk chk (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timerIn, .timerOut, .timerOutComp, .timerOutCompEnN, .timerIrq);

// ---- tcgc_partner.sv ----
// Far-side model of the shared timer pin.
// The bench commands the level; the model moves it after an edge.
`timescale 1ns/1ps
module tcgc_partner
(
    input wire logic clock,
    input wire logic level,
    input wire logic timerOutComp,
    input wire logic timerOutCompEnN,
    output logic timerIn
);
    logic drive_r = 1'b0;
    always_ff @(posedge clock)
    begin
        drive_r <= level;
    end
    // once the device drives the pin, it reads back its own level
    assign timerIn = timerOutCompEnN ? drive_r : timerOutComp;
endmodule // tcgc_partner

// ---- tcgc_tb.sv ----
// Bench for the timer: APB tasks, partner on the pin.
// Zero-wait APB slave assumed only through pready.
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, timerIn, timerOut, timerOutComp, timerOutCompEnN, timerIrq;
    logic level = 1'b0;
    logic [31:0] rd;
    logic [31:0] ctl;
    logic err;
    logic lvl;
    int n_mismatch = 0;
    int tests_run = 0;
    int gap;
    always #50 clock = ~clock;
    tcgc_timer uut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .timerIn, .timerOut, .timerOutComp, .timerOutCompEnN, .timerIrq);
    tcgc_partner far (.clock, .level, .timerOutComp, .timerOutCompEnN, .timerIn);
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic waitIrq(input int lim);
        gap = 0;
        do
        begin
            @(posedge clock);
            gap++;
        end while (timerIrq !== 1'b1 && gap < lim);
    endtask
    task automatic setup(input logic [31:0] c0, input logic [31:0] c1, input logic [15:0] cnt, input logic [15:0] rl);
        ctl = c1;
        apb(1'b1, tcgc_pkg::ADDR_CTL1, c1);
        apb(1'b1, tcgc_pkg::ADDR_CTL0, c0);
        apb(1'b1, tcgc_pkg::ADDR_CNTH, {24'h0, cnt[15:8]});
        apb(1'b1, tcgc_pkg::ADDR_CNTL, {24'h0, cnt[7:0]});
        apb(1'b1, tcgc_pkg::ADDR_RLDH, {24'h0, rl[15:8]});
        apb(1'b1, tcgc_pkg::ADDR_RLDL, {24'h0, rl[7:0]});
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, tcgc_pkg::ADDR_CTL1, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b0, tcgc_pkg::ADDR_RLDL, 32'h0);
        check(rd, 32'h0000_00FF);
        apb(1'b0, 12'h024, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, tcgc_pkg::ADDR_CNTL, 32'h34);
        apb(1'b0, tcgc_pkg::ADDR_CNTL, 32'h0);
        check(rd, 32'h0000_0034);
        // Compare: start near the top so a match needs the wrap
        setup(32'h0, 32'h02, 16'hFFFE, 16'h0002);
        level <= 1'b1;
        lvl = timerOut;
        apb(1'b1, tcgc_pkg::ADDR_CTL1, 32'h82);
        waitIrq(20);
        check({31'h0, gap < 20}, 32'h1);
        repeat (2) @(posedge clock);
        check({31'h0, timerOut}, {31'h0, ~lvl});
        waitIrq(40);
        check(gap, 32'd40);
        // Gated: two prescales with both sources, then input events only
        for (int k = 0; k < 3; k++)
        begin
            setup(k == 2 ? 32'h40 : 32'h0, k == 1 ? 32'h4E : 32'h46, 16'h0002, 16'h0004);
            level <= 1'b0;
            apb(1'b1, tcgc_pkg::ADDR_CTL1, ctl | 32'h80);
            waitIrq(10);
            check(gap, 32'd10);
            apb(1'b0, tcgc_pkg::ADDR_CNTH, 32'h0);
            check(rd, 32'h0000_0000);
            apb(1'b0, tcgc_pkg::ADDR_CNTL, 32'h0);
            check(rd, 32'h0000_0002);
            level <= 1'b1;
            waitIrq(20);
            waitIrq(40);
            check(gap, k == 2 ? 32'd40 : (32'd4 << k));
            level <= 1'b0;
            waitIrq(6);
            check({31'h0, gap < 6}, 32'h1);
            apb(1'b1, tcgc_pkg::ADDR_CTL1, ctl);
        end
        // Capture/compare on rising edges
        setup(32'h0, 32'h47, 16'h0001, 16'h0040);
        apb(1'b1, tcgc_pkg::ADDR_CTL1, 32'hC7);
        apb(1'b0, tcgc_pkg::ADDR_CNTH, 32'h0);
        apb(1'b0, tcgc_pkg::ADDR_CNTL, 32'h0);
        check(rd, 32'h0000_0001);
        level <= 1'b1;
        waitIrq(8);
        check(gap, 32'd8);
        level <= 1'b0;
        repeat (3) @(posedge clock);
        level <= 1'b1;
        waitIrq(5);
        check({31'h0, gap < 5}, 32'h1);
        apb(1'b0, tcgc_pkg::ADDR_CTL0, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        apb(1'b0, tcgc_pkg::ADDR_CAPL, 32'h0);
        check({31'h0, rd > 32'h8}, 32'h1);
        waitIrq(80);
        check({31'h0, gap < 80}, 32'h1);
        apb(1'b1, tcgc_pkg::ADDR_CTL0, 32'h01);
        apb(1'b0, tcgc_pkg::ADDR_CTL0, 32'h0);
        check({31'h0, rd[0]}, 32'h0);
        // Dual output mode turns the shared pin around
        setup(32'h80, 32'h00, 16'h0001, 16'h0040);
        apb(1'b1, tcgc_pkg::ADDR_OUTC, 32'h1);
        // Pin enable is registered at the access edge; look one edge later
        @(posedge clock);
        check({31'h0, timerOutCompEnN}, 32'h0);
        apb(1'b1, tcgc_pkg::ADDR_CTL0, 32'h0);
        @(posedge clock);
        check({31'h0, timerOutCompEnN}, 32'h1);
        report_and_stop();
    end
endmodule // tb
